// ### sim/bar_core_test.sv
/*
 * Self-checking bench for bar_core: random and corner buffer requests, registers.
 * Assumes bar_mem_model returns load data after each issue.
 */
`timescale 1ns/10ps
module bar_core_test;
  import bar_pkg::*;
  logic clk_i, reset_i, req_valid_i, req_ready_o, hw_i, hw_high_i, offen_i, idxen_i, issue_valid_o;
  bar_op_t op_i;
  bar_size_t size_i;
  logic [3:0] inst_dfmt_i, dfmt_o, avs_address_i;
  logic [2:0] inst_nfmt_i, nfmt_o;
  logic [11:0] inst_offset_i;
  logic [127:0] desc_i, d;
  logic [31:0] soffset_i, avs_writedata_i, avs_readdata_o, q;
  logic [LANES-1:0][31:0] vindex_i, voffset_i;
  logic [LANES-1:0][3:0][31:0] vdata_i, st_data_o, ret_data_i, ret_data_o;
  logic [LANES-1:0][47:0] addr_o;
  logic [LANES-1:0][3:0] comp_ok_o;
  logic [3:0][2:0] dst_sel_o;
  logic [4:0] elem_size_o;
  logic [1:0] ret_hmask_o;
  logic ret_valid_i, ret_valid_o, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] tf [4] = '{DF_32, DF_32X2, DF_32X3, DF_32X4};
  int n_errors, checks, n_req, k;

  bar_core u_bar_core (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .op_i(op_i), .size_i(size_i), .hw_i(hw_i), .hw_high_i(hw_high_i), .inst_dfmt_i(inst_dfmt_i),
    .inst_nfmt_i(inst_nfmt_i), .inst_offset_i(inst_offset_i), .offen_i(offen_i), .idxen_i(idxen_i),
    .desc_i(desc_i), .soffset_i(soffset_i), .vindex_i(vindex_i), .voffset_i(voffset_i), .vdata_i(vdata_i),
    .issue_valid_o(issue_valid_o), .addr_o(addr_o), .comp_ok_o(comp_ok_o), .dfmt_o(dfmt_o), .nfmt_o(nfmt_o),
    .dst_sel_o(dst_sel_o), .elem_size_o(elem_size_o), .st_data_o(st_data_o), .ret_valid_i(ret_valid_i),
    .ret_data_i(ret_data_i), .ret_valid_o(ret_valid_o), .ret_data_o(ret_data_o), .ret_hmask_o(ret_hmask_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  bar_mem_model u_bar_mem_model (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue_valid_o),
    .ret_valid_o(ret_valid_i), .ret_data_o(ret_data_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp

  function automatic logic [17:0] strd();
    if (desc_i[119] && (op_i == OP_USIZED || op_i == OP_ATOMIC))
      return {desc_i[114:111], desc_i[61:48]};
    return {4'h0, desc_i[61:48]};
  endfunction : strd

  function automatic logic [47:0] eaddr(int l, int esz);
    logic [31:0] ix, of, es, is;
    logic [47:0] bo;
    ix = (idxen_i ? vindex_i[l] : 32'h0) + (desc_i[119] ? 32'(l) : 32'h0);
    of = (offen_i ? voffset_i[l] : 32'h0) + 32'(inst_offset_i);
    es = 32'h2 << desc_i[121:120];
    is = 32'h8 << desc_i[118:117];
    if (desc_i[63])
      bo = 48'((ix / is * strd() + of / es * es) * is + ix % is * es + of % es);
    else
      bo = 48'(of) + 48'(strd()) * 48'(ix);
    bo = desc_i[47:0] + 48'(soffset_i) + bo;
    if (esz >= 4)
      bo[1:0] = 2'b00;
    return bo;
  endfunction : eaddr

  function automatic logic okx(int l, int c, bit whole);
    logic [31:0] of;
    of = (offen_i ? voffset_i[l] : 32'h0) + 32'(inst_offset_i);
    if (desc_i[114:111] == DF_INVALID && !(desc_i[119] && (op_i == OP_USIZED || op_i == OP_ATOMIC)))
      return 1'b0;
    if (desc_i[119] && !idxen_i)
      return 1'b1;
    if (!desc_i[119] && !desc_i[63] && !idxen_i)
      return (whole ? of : of + 32'(4 * c)) < desc_i[95:64];
    if (!desc_i[119] && desc_i[61:48] != 14'h0 && idxen_i)
      return vindex_i[l] < desc_i[95:64];
    return 1'b1;
  endfunction : okx

  function automatic logic [11:0] idsel(int n);
    logic [3:0][2:0] s;
    for (int c = 0; c < 4; c++)
      s[c] = c < n ? SEL_X + 3'(c) : SEL_0;
    return s;
  endfunction : idsel

  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : avs

  task automatic setup(input logic [127:0] dd, input logic [11:0] io, input logic oe, input logic ie);
    @(posedge clk_i);
    desc_i <= dd;
    soffset_i <= $urandom;
    inst_offset_i <= io;
    offen_i <= oe;
    idxen_i <= ie;
    for (int l = 0; l < LANES; l++) begin
      vindex_i[l] <= $urandom_range(63);
      voffset_i[l] <= 32'(4 * $urandom_range(1023));
      for (int c = 0; c < 4; c++)
        vdata_i[l][c] <= $urandom;
    end
  endtask : setup

  task automatic go(input bar_op_t op, input bar_size_t sz, input logic hw, input logic hh, input int esz,
                    input int nc, input bit whole);
    int n;
    @(posedge clk_i);
    op_i <= op;
    size_i <= sz;
    hw_i <= hw;
    hw_high_i <= hh;
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n_req++;
    @(negedge clk_i);
    cmp("issue", 1, issue_valid_o);
    cmp("esize", esz, elem_size_o);
    for (int l = 0; l < LANES; l++) begin
      cmp("addr", eaddr(l, esz), addr_o[l]);
      for (int c = 0; c < nc; c++)
        cmp("inrange", okx(l, c, whole), comp_ok_o[l][c]);
    end
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ret_valid_o !== 1'b1 && n < 12);
    cmp("retvalid", 1, ret_valid_o);
  endtask : go

  initial begin
    #750000;
    n_errors++;
    conclude();
  end

  initial begin
    reset_i = 1'b1;
    {req_valid_i, hw_i, hw_high_i, offen_i, idxen_i, avs_read_i, avs_write_i} = '0;
    {desc_i, soffset_i, vindex_i, voffset_i, vdata_i, inst_offset_i, avs_address_i, avs_writedata_i} = '0;
    op_i = OP_USIZED;
    size_i = SZ_DWORD;
    inst_dfmt_i = DF_32;
    inst_nfmt_i = NF_UINT;
    void'($urandom(32'h04C1));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    cmp("ready", 1, req_ready_o);
    avs(1'b0, REG_CTRL, 32'h0, q);
    cmp("ctrl", 1, q);
    avs(1'b1, 4'hC, 32'hFFFFFFFF, q);
    avs(1'b0, 4'hC, 32'h0, q);
    cmp("unmapped", 0, q);
    // classes: raw x4, structured, scratch, swizzled structured
    for (int i = 0; i < 8; i++) begin
      k = i % 4;
      d = '0;
      d[47:0] = {16'($urandom), $urandom};
      d[61:48] = 14'(16 * (1 + $urandom_range(40)));
      d[63] = (k == 3);
      d[95:64] = k == 0 ? $urandom_range(6000) : $urandom_range(64);
      d[114:111] = 4'(1 + $urandom_range(13));
      d[118:117] = 2'($urandom_range(3));
      d[119] = (k == 2);
      d[121:120] = 2'(1 + $urandom_range(2));
      setup(d, 12'(4 * $urandom_range(1023)), 1'($urandom), k == 1 || k == 3);
      go(OP_USIZED, k == 0 ? SZ_X4 : SZ_DWORD, 1'b0, 1'b0, k == 0 ? 16 : 4, k == 0 ? 4 : 1, 1'b0);
      cmp("dfmt", k == 0 ? DF_32X4 : DF_32, dfmt_o);
      cmp("nfmt", NF_UINT, nfmt_o);
      cmp("sel", idsel(k == 0 ? 4 : 1), dst_sel_o);
      for (int l = 0; l < LANES; l++)
        for (int c = 0; c < (k == 0 ? 4 : 1); c++)
          cmp("ret", okx(l, c, 0) ? 32'hC0DE5A00 | 32'(l * 4 + c) : 32'h0, ret_data_o[l][c]);
    end
    d = '0;
    d[95:64] = 32'd2048;
    d[114:111] = DF_32;
    for (int i = 0; i < 4; i++) begin
      setup(d, 12'h010, 1'b1, 1'b0);
      inst_dfmt_i <= tf[i];
      inst_nfmt_i <= NF_FLOAT;
      go(OP_TYPED, SZ_DWORD, 1'b0, 1'b0, 4 * (i + 1), i + 1, 1'b1);
      cmp("tdfmt", tf[i], dfmt_o);
      cmp("tnfmt", NF_FLOAT, nfmt_o);
      cmp("tsel", idsel(i + 1), dst_sel_o);
    end
    d[95:64] = 32'h100000;
    d[114:111] = DF_32X4;
    d[110:108] = NF_FLOAT;
    setup(d, 12'h123, 1'b0, 1'b0);
    go(OP_USIZED, SZ_UBYTE, 1'b1, 1'b0, 1, 1, 1'b1);
    cmp("bdfmt", DF_8, dfmt_o);
    cmp("bnfmt", NF_UINT, nfmt_o);
    cmp("hmask", 2'b01, ret_hmask_o);
    for (int l = 0; l < LANES; l++)
      cmp("bytelow", {8'h00, 8'(l * 4)}, ret_data_o[l][0][15:0]);
    go(OP_USIZED, SZ_USHORT, 1'b1, 1'b1, 2, 1, 1'b1);
    cmp("hmask", 2'b10, ret_hmask_o);
    for (int l = 0; l < LANES; l++) begin
      cmp("sthigh", {16'h0, vdata_i[l][0][31:16]}, st_data_o[l][0]);
      cmp("sthigh1", 0, st_data_o[l][1]);
      cmp("ldhigh", 16'h5A00 | 16'(l * 4), ret_data_o[l][0][31:16]);
    end
    d[107:96] = {SEL_X + 3'h3, SEL_X + 3'h2, SEL_X + 3'h1, SEL_X};
    d[110:108] = NF_UINT;
    setup(d, 12'h020, 1'b1, 1'b0);
    go(OP_UFMT, SZ_DWORD, 1'b1, 1'b0, 16, 4, 1'b1);
    cmp("fsel", d[107:96], dst_sel_o);
    cmp("fdfmt", DF_32X4, dfmt_o);
    for (int l = 0; l < LANES; l++) begin
      for (int c = 0; c < 4; c++)
        cmp("hstore", {16'h0, vdata_i[l][c / 2][16 * (c % 2) +: 16]}, st_data_o[l][c]);
      for (int r = 0; r < 2; r++)
        cmp("hload", {16'h5A00 | 16'(l * 4 + 2 * r + 1), 16'h5A00 | 16'(l * 4 + 2 * r)}, ret_data_o[l][r]);
    end
    d[114:111] = DF_32;
    d[98:96] = SEL_1;
    d[95:64] = 32'h0;
    setup(d, 12'h000, 1'b0, 1'b0);
    go(OP_UFMT, SZ_DWORD, 1'b0, 1'b0, 4, 1, 1'b1);
    for (int l = 0; l < LANES; l++)
      cmp("selone", ONE_INT, ret_data_o[l][0]);
    avs(1'b0, REG_STAT, 32'h0, q);
    cmp("stat", 64, q[6:0]);
    // invalid format on an atomic first, then an all-zero descriptor
    for (int i = 0; i < 2; i++) begin
      d[114:111] = DF_INVALID;
      d[95:64] = 32'hFFFF;
      if (i == 1)
        d = '0;
      setup(d, 12'h040, 1'b0, 1'b0);
      go(i == 0 ? OP_ATOMIC : OP_USIZED, SZ_DWORD, 1'b0, 1'b0, 4, 1, 1'b1);
      cmp("udfmt", DF_INVALID, dfmt_o);
      for (int l = 0; l < LANES; l++)
        cmp("unbound", 0, ret_data_o[l][0]);
    end
    avs(1'b0, REG_CNT, 32'h0, q);
    cmp("count", n_req, q);
    avs(1'b1, REG_CTRL, 32'h0, q);
    @(negedge clk_i);
    cmp("readyoff", 0, req_ready_o);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(negedge clk_i);
    cmp("refused", 0, issue_valid_o);
    avs(1'b1, REG_CTRL, 32'h1, q);
    avs(1'b1, REG_CNT, 32'h0, q);
    avs(1'b0, REG_CNT, 32'h0, q);
    cmp("countclr", 0, q);
    conclude();
  end
endmodule : bar_core_test

// ### sim/bar_mem_model.sv
/*
 * Memory path model for bar_core: answers each issue pulse with one load return.
 * Assumes one outstanding request, as the issue side of the bench keeps.
 */
`timescale 1ns/10ps
module bar_mem_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic issue_i,
  output logic ret_valid_o,
  output logic [bar_pkg::LANES-1:0][3:0][31:0] ret_data_o
);
  import bar_pkg::*;
  int cnt;
  initial begin
    ret_valid_o = 1'b0;
    ret_data_o = '0;
    cnt = 0;
  end
  // latency varies so a design that samples a fixed cycle is caught
  always @(posedge clk_i) begin
    if (reset_i)
      cnt <= 0;
    else if (issue_i)
      cnt <= 1 + $urandom_range(3);
    else if (cnt > 0)
      cnt <= cnt - 1;
    ret_valid_o <= !reset_i && !issue_i && cnt == 1;
    if (!reset_i && !issue_i && cnt == 1) begin
      for (int l = 0; l < LANES; l++)
        for (int c = 0; c < 4; c++)
          ret_data_o[l][c] <= 32'hC0DE5A00 | 32'(l * 4 + c);
    end else begin
      // idle data keeps moving so a stale capture shows
      ret_data_o <= ~ret_data_o;
    end
  end
endmodule : bar_mem_model

// ### src/bar_core.sv
/*
 * Per-lane buffer address generation, range check and half-word packing.
 * Assumes issue logic on req_*, a memory path on issue_* and ret_*,
 * one outstanding return context, registers on Avalon-MM.
 */
// Contract
// - typed ops use instruction formats; untyped format uses descriptor; others derive
// - derived format ignores descriptor fields; unsigned byte gives format 8, uint
// - invalid descriptor format means unbound and is never replaced, except by the instruction format on typed ops
// - identity select by component count: X000, XY00, XYZ0, XYZW
// - half-word stores take two 16-bit elements per 32-bit register
// - half-word loads pack pairs low half first; numeric format picks int/float
// - literal instruction offset always added to the offset term
// - element size from memory format or opcode: 1, 2, 4, 8, 12 or 16 bytes
// - lane-number sized and atomic ops use 18-bit stride, else 14-bit zero-extended
// - record count is bytes for raw, strides for structured, ignored for scratch
// - linear address is base+scalar+inst+vector offset+stride*(index+lane)
// - index and offset terms built from enables, lane bits and literal offset
// - out-of-range loads return zero; stores and atomics are dropped
// - lane-number add with index disabled is scratch, never range checked
// - raw buffer out of range when offset term reaches the record count
// - structured buffer out of range when vector index reaches the record count
// - out-of-range components read zero, or one where select is constant one
// - format ops and atomics checked whole; multi-dword loads per component
// - swizzled offset from index and offset quotients and remainders
// - swizzle element size 2..16 bytes, index stride 8..64, only when swizzled
// - low variant uses bits 15:0, high variant bits 31:16; unsigned bytes zero-extend
// - dword or larger accesses clear the two low address bits
// - an all-zero descriptor acts unbound and loads read zero
`timescale 1ns/10ps
module bar_core #(
  parameter int LANES = bar_pkg::LANES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire bar_pkg::bar_op_t op_i,
  input wire bar_pkg::bar_size_t size_i,
  input wire logic hw_i,
  input wire logic hw_high_i,
  input wire logic [3:0] inst_dfmt_i,
  input wire logic [2:0] inst_nfmt_i,
  input wire logic [11:0] inst_offset_i,
  input wire logic offen_i,
  input wire logic idxen_i,
  input wire logic [127:0] desc_i,
  input wire logic [31:0] soffset_i,
  input wire logic [LANES-1:0][31:0] vindex_i,
  input wire logic [LANES-1:0][31:0] voffset_i,
  input wire logic [LANES-1:0][3:0][31:0] vdata_i,
  output logic issue_valid_o,
  output logic [LANES-1:0][47:0] addr_o,
  output logic [LANES-1:0][3:0] comp_ok_o,
  output logic [3:0] dfmt_o,
  output logic [2:0] nfmt_o,
  output logic [3:0][2:0] dst_sel_o,
  output logic [4:0] elem_size_o,
  output logic [LANES-1:0][3:0][31:0] st_data_o,
  input wire logic ret_valid_i,
  input wire logic [LANES-1:0][3:0][31:0] ret_data_i,
  output logic ret_valid_o,
  output logic [LANES-1:0][3:0][31:0] ret_data_o,
  output logic [1:0] ret_hmask_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import bar_pkg::*;

  function automatic logic [4:0] fmt_bytes(input logic [3:0] f);
    case (f)
      4'h1: fmt_bytes = 5'h01;
      4'h2, 4'h3: fmt_bytes = 5'h02;
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: fmt_bytes = 5'h04;
      4'hB, 4'hC: fmt_bytes = 5'h08;
      4'hD: fmt_bytes = 5'h0C;
      4'hE: fmt_bytes = 5'h10;
      default: fmt_bytes = 5'h00;
    endcase
  endfunction : fmt_bytes

  function automatic logic [2:0] fmt_comps(input logic [3:0] f);
    case (f)
      4'h1, 4'h2, 4'h4: fmt_comps = 3'h1;
      4'h3, 4'h5, 4'hB: fmt_comps = 3'h2;
      4'h6, 4'h7, 4'hD: fmt_comps = 3'h3;
      4'h8, 4'h9, 4'hA, 4'hC, 4'hE: fmt_comps = 3'h4;
      default: fmt_comps = 3'h0;
    endcase
  endfunction : fmt_comps

  // no rounding, denormals flush to zero: cheap and monotonic
  function automatic logic [15:0] f32_to_f16(input logic [31:0] v);
    logic [8:0] e;
    e = {1'b0, v[30:23]} - 9'h070;
    if (v[30:23] == 8'hFF) begin
      f32_to_f16 = {v[31], 5'h1F, v[22:13] | {9'h000, |v[22:0]}};
    end else if (v[30:23] <= 8'h70) begin
      f32_to_f16 = {v[31], 15'h0000};
    end else if (e >= 9'h01F) begin
      f32_to_f16 = {v[31], 5'h1F, 10'h000};
    end else begin
      f32_to_f16 = {v[31], e[4:0], v[22:13]};
    end
  endfunction : f32_to_f16

  logic ctrl_en_r;
  logic ack_r;
  logic [6:0] oor_lanes_r;
  logic [31:0] req_cnt_r;
  logic accept;
  logic add_tid, swz_en, non_fmt, unbound, per_comp, scratch, raw, structd;
  logic [3:0] d_dfmt, sel_dfmt;
  logic [2:0] sel_nfmt, ncomp;
  logic [3:0][2:0] sel_dst;
  logic [17:0] stride;
  logic [31:0] nrec;
  logic [4:0] esize, eshift, ishift;
  logic [LANES-1:0][3:0] oor;
  logic [6:0] oor_count;

  assign accept = req_valid_i && req_ready_o;
  assign req_ready_o = ctrl_en_r;
  assign d_dfmt = desc_i[D_DFMT_LSB +: 4];
  assign add_tid = desc_i[D_TID_BIT];
  assign swz_en = desc_i[D_SWZ_BIT];
  assign nrec = desc_i[D_NREC_LSB +: 32];
  assign non_fmt = (op_i == OP_USIZED) || (op_i == OP_ATOMIC);
  // descriptor format bits double as stride high bits here, not a format
  assign unbound = (d_dfmt == DF_INVALID) && !(add_tid && non_fmt);
  assign stride = (add_tid && non_fmt) ? {d_dfmt, desc_i[D_STRIDE_LSB +: 14]}
                                       : {4'h0, desc_i[D_STRIDE_LSB +: 14]};
  assign per_comp = (op_i == OP_USIZED) && (size_i >= SZ_X2);
  assign scratch = add_tid && !idxen_i;
  assign raw = !add_tid && !swz_en && !idxen_i;
  assign structd = !add_tid && (stride != 18'h0) && idxen_i;
  assign eshift = {3'h0, desc_i[D_ESZ_LSB +: 2]} + 5'h01;
  assign ishift = {3'h0, desc_i[D_ISTR_LSB +: 2]} + 5'h03;

  always_comb begin
    sel_nfmt = NF_UINT;
    sel_dfmt = DF_32;
    case (op_i)
      OP_TYPED: begin
        sel_dfmt = inst_dfmt_i;
        sel_nfmt = inst_nfmt_i;
      end
      OP_UFMT: begin
        sel_dfmt = d_dfmt;
        sel_nfmt = desc_i[D_NFMT_LSB +: 3];
      end
      OP_USIZED: begin
        case (size_i)
          SZ_UBYTE: sel_dfmt = DF_8;
          SZ_SBYTE: sel_dfmt = DF_8;
          SZ_USHORT: sel_dfmt = DF_16;
          SZ_SSHORT: sel_dfmt = DF_16;
          SZ_X2: sel_dfmt = DF_32X2;
          SZ_X3: sel_dfmt = DF_32X3;
          SZ_X4: sel_dfmt = DF_32X4;
          default: sel_dfmt = DF_32;
        endcase
        sel_nfmt = (size_i == SZ_SBYTE || size_i == SZ_SSHORT) ? NF_SINT : NF_UINT;
      end
      default: begin
        sel_dfmt = DF_32;
        sel_nfmt = NF_UINT;
      end
    endcase
  end

  assign ncomp = fmt_comps(sel_dfmt);
  assign esize = fmt_bytes(sel_dfmt);

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      sel_dst[c] = (3'(c) < ncomp) ? SEL_X + 3'(c) : SEL_0;
      if (op_i == OP_UFMT) begin
        sel_dst[c] = desc_i[D_SEL_LSB + 3*c +: 3];
      end
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [31:0] idx, off;
    logic [31:0] imsb, ilsb, omsb, olsb;
    logic [47:0] lin, swz, sum;
    logic [3:0][31:0] st;

    always_comb begin
      idx = (idxen_i ? vindex_i[l] : 32'h0) + (add_tid ? 32'(l) : 32'h0);
      off = (offen_i ? voffset_i[l] : 32'h0) + {20'h00000, inst_offset_i};
      lin = 48'(off) + 48'(48'(stride) * 48'(idx));
      imsb = idx >> ishift;
      ilsb = idx & ((32'h1 << ishift) - 32'h1);
      omsb = off >> eshift;
      olsb = off & ((32'h1 << eshift) - 32'h1);
      swz = ((48'(48'(imsb) * 48'(stride)) + (48'(omsb) << eshift)) << ishift)
            + (48'(ilsb) << eshift) + 48'(olsb);
      sum = desc_i[47:0] + 48'(soffset_i) + (swz_en ? swz : lin);
      if (esize >= 5'h04) begin
        sum[1:0] = 2'b00;
      end
      for (int c = 0; c < 4; c++) begin
        oor[l][c] = 1'b0;
        if (unbound) begin
          oor[l][c] = 1'b1;
        end else if (scratch) begin
          oor[l][c] = 1'b0;
        end else if (raw) begin
          oor[l][c] = per_comp ? ({1'b0, off} + 33'(4*c) >= {1'b0, nrec}) : (off >= nrec);
        end else if (structd) begin
          oor[l][c] = idx >= nrec;
        end
      end
      st = vdata_i[l];
      if (hw_i && (op_i == OP_TYPED || op_i == OP_UFMT)) begin
        for (int c = 0; c < 4; c++) begin
          st[c] = {16'h0000, vdata_i[l][c/2][16*(c%2) +: 16]};
        end
      end else if (hw_i) begin
        st = '0;
        st[0] = {16'h0000, hw_high_i ? vdata_i[l][0][31:16] : vdata_i[l][0][15:0]};
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        addr_o[l] <= '0;
        comp_ok_o[l] <= '0;
        st_data_o[l] <= '0;
      end else if (accept) begin
        addr_o[l] <= sum;
        comp_ok_o[l] <= ~oor[l];
        st_data_o[l] <= st;
      end
    end
  end

  logic [LANES-1:0][3:0] ctx_oor_r;
  logic [3:0][2:0] ctx_sel_r;
  logic ctx_unbound_r, ctx_float_r, ctx_hw_r, ctx_hwhi_r, ctx_fmt_r, ctx_byte_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      issue_valid_o <= 1'b0;
      dfmt_o <= DF_INVALID;
      nfmt_o <= NF_UINT;
      dst_sel_o <= '0;
      elem_size_o <= '0;
    end else begin
      issue_valid_o <= accept;
      if (accept) begin
        dfmt_o <= (unbound && op_i != OP_TYPED) ? DF_INVALID : sel_dfmt;
        nfmt_o <= sel_nfmt;
        dst_sel_o <= sel_dst;
        elem_size_o <= esize;
      end
    end
  end

  // one return context: the memory path answers one load before the next issue
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctx_oor_r <= '0;
      ctx_sel_r <= '0;
      ctx_unbound_r <= 1'b0;
      ctx_float_r <= 1'b0;
      ctx_hw_r <= 1'b0;
      ctx_hwhi_r <= 1'b0;
      ctx_fmt_r <= 1'b0;
      ctx_byte_r <= 1'b0;
    end else if (accept) begin
      ctx_oor_r <= oor;
      ctx_sel_r <= sel_dst;
      ctx_unbound_r <= unbound || (op_i == OP_TYPED && d_dfmt == DF_INVALID);
      ctx_float_r <= sel_nfmt == NF_FLOAT;
      ctx_hw_r <= hw_i;
      ctx_hwhi_r <= hw_high_i;
      ctx_fmt_r <= op_i == OP_TYPED || op_i == OP_UFMT;
      ctx_byte_r <= op_i == OP_USIZED && size_i == SZ_UBYTE;
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_ret
    logic [3:0][31:0] v;
    logic [3:0][15:0] h;
    logic [3:0][31:0] o;

    always_comb begin
      for (int c = 0; c < 4; c++) begin
        v[c] = ret_data_i[l][c];
        if (ctx_unbound_r) begin
          v[c] = 32'h0;
        end else if (ctx_oor_r[l][c]) begin
          v[c] = (ctx_sel_r[c] == SEL_1) ? (ctx_float_r ? ONE_F32 : ONE_INT) : 32'h0;
        end
        h[c] = ctx_float_r ? f32_to_f16(v[c]) : ctx_byte_r ? {8'h00, v[c][7:0]} : v[c][15:0];
      end
      o = v;
      if (ctx_hw_r && ctx_fmt_r) begin
        o = '0;
        o[0] = {h[1], h[0]};
        o[1] = {h[3], h[2]};
      end else if (ctx_hw_r) begin
        o = '0;
        o[0] = ctx_hwhi_r ? {h[0], 16'h0000} : {16'h0000, h[0]};
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        ret_data_o[l] <= '0;
      end else if (ret_valid_i) begin
        ret_data_o[l] <= o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ret_valid_o <= 1'b0;
      ret_hmask_o <= 2'b11;
    end else begin
      ret_valid_o <= ret_valid_i;
      if (ret_valid_i) begin
        ret_hmask_o <= (ctx_hw_r && !ctx_fmt_r) ? (ctx_hwhi_r ? 2'b10 : 2'b01) : 2'b11;
      end
    end
  end

  always_comb begin
    oor_count = 7'h00;
    for (int l = 0; l < LANES; l++) begin
      oor_count = oor_count + {6'h00, |oor[l]};
    end
  end

  // two-cycle slave: readdata loads in the waiting cycle, writes land on the released edge
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      if (avs_read_i && !ack_r) begin
        case ({avs_address_i[3:2], 2'b00})
          REG_CTRL: avs_readdata_o <= {31'h0, ctrl_en_r};
          REG_STAT: avs_readdata_o <= {25'h0, oor_lanes_r};
          REG_CNT: avs_readdata_o <= req_cnt_r;
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_en_r <= CTRL_RESET;
    end else if (avs_write_i && ack_r && {avs_address_i[3:2], 2'b00} == REG_CTRL) begin
      ctrl_en_r <= avs_writedata_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oor_lanes_r <= 7'h00;
      req_cnt_r <= 32'h0;
    end else begin
      if (accept) begin
        oor_lanes_r <= oor_count;
        req_cnt_r <= req_cnt_r + 32'h1;
      end else if (avs_write_i && ack_r && {avs_address_i[3:2], 2'b00} == REG_CNT) begin
        req_cnt_r <= 32'h0;
      end
    end
  end

  a_issue_follows: assert property (@(posedge clk_i) disable iff (reset_i)
    accept |=> issue_valid_o && $past(ctrl_en_r)) else $error("issue did not follow accept");
  a_derived_byte: assert property (@(posedge clk_i) disable iff (reset_i)
    accept && op_i == OP_USIZED && size_i == SZ_UBYTE && d_dfmt != DF_INVALID
    |=> dfmt_o == DF_8 && nfmt_o == NF_UINT) else $error("unsigned byte format wrong");
  a_invalid_kept: assert property (@(posedge clk_i) disable iff (reset_i)
    accept && op_i == OP_ATOMIC && d_dfmt == DF_INVALID && !add_tid
    |=> dfmt_o == DF_INVALID) else $error("invalid format was replaced");
  a_identity_x: assert property (@(posedge clk_i) disable iff (reset_i)
    accept && op_i == OP_TYPED && inst_dfmt_i == DF_32
    |=> dst_sel_o == {SEL_0, SEL_0, SEL_0, SEL_X}) else $error("identity select wrong");
  a_dword_align: assert property (@(posedge clk_i) disable iff (reset_i)
    issue_valid_o && elem_size_o >= 5'h04 |-> addr_o[0][1:0] == 2'b00) else $error("address not aligned");
  a_scratch_nochk: assert property (@(posedge clk_i) disable iff (reset_i)
    accept && add_tid && !idxen_i && non_fmt |=> comp_ok_o[LANES-1] == 4'hF) else $error("scratch was checked");
  a_raw_oor: assert property (@(posedge clk_i) disable iff (reset_i)
    accept && raw && !unbound && !offen_i && {20'h0, inst_offset_i} >= nrec
    |=> comp_ok_o[0] == 4'h0) else $error("raw access not refused");
  a_struct_oor: assert property (@(posedge clk_i) disable iff (reset_i)
    accept && structd && !unbound && vindex_i[0] >= nrec |=> comp_ok_o[0] == 4'h0) else $error("structured not refused");
  a_unbound_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    ret_valid_i && ctx_unbound_r && !ctx_hw_r |=> ret_data_o[0] == '0) else $error("unbound load not zero");
  a_ready_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    avs_write_i && !avs_waitrequest_o && avs_address_i[3:2] == 2'b00 && !avs_writedata_i[0]
    |=> !req_ready_o) else $error("ready while disabled");
endmodule : bar_core

// ### src/bar_pkg.sv
/*
 * Constants and types for the buffer address and range check block.
 * Assumes a 128-bit buffer descriptor and a 64-lane wave.
 */
package bar_pkg;
  localparam int LANES = 64;
  // descriptor field positions
  localparam int D_STRIDE_LSB = 48;
  localparam int D_SWZ_BIT = 63;
  localparam int D_NREC_LSB = 64;
  localparam int D_SEL_LSB = 96;
  localparam int D_NFMT_LSB = 108;
  localparam int D_DFMT_LSB = 111;
  localparam int D_ISTR_LSB = 117;
  localparam int D_TID_BIT = 119;
  localparam int D_ESZ_LSB = 120;
  // data formats
  localparam logic [3:0] DF_INVALID = 4'h0;
  localparam logic [3:0] DF_8 = 4'h1;
  localparam logic [3:0] DF_16 = 4'h2;
  localparam logic [3:0] DF_32 = 4'h4;
  localparam logic [3:0] DF_32X2 = 4'hB;
  localparam logic [3:0] DF_32X3 = 4'hD;
  localparam logic [3:0] DF_32X4 = 4'hE;
  // numeric formats
  localparam logic [2:0] NF_UINT = 3'h4;
  localparam logic [2:0] NF_SINT = 3'h5;
  localparam logic [2:0] NF_FLOAT = 3'h7;
  // channel selects
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_X = 3'h4;
  localparam logic [31:0] ONE_INT = 32'h00000001;
  localparam logic [31:0] ONE_F32 = 32'h3F800000;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CNT = 4'h8;
  localparam logic CTRL_RESET = 1'b1;
  typedef enum logic [1:0] {
    OP_TYPED = 2'b00,
    OP_UFMT = 2'b01,
    OP_USIZED = 2'b10,
    OP_ATOMIC = 2'b11
  } bar_op_t;
  typedef enum logic [2:0] {
    SZ_UBYTE = 3'b000,
    SZ_SBYTE = 3'b001,
    SZ_USHORT = 3'b010,
    SZ_SSHORT = 3'b011,
    SZ_DWORD = 3'b100,
    SZ_X2 = 3'b101,
    SZ_X3 = 3'b110,
    SZ_X4 = 3'b111
  } bar_size_t;
endpackage : bar_pkg
